// >>> logic/timer_cfg.svh
// register indices, field positions and fixed values of the timer block
// assumes byte address = 4 * index on a 32-bit register bus
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define MAX_CH 6
`define IDX_LSB 2
`define IDX_MSB 7
`define IDX_DIR 6'h00
`define IDX_FORCE 6'h01
`define IDX_CNT_HI 6'h04
`define IDX_CNT_LO 6'h05
`define IDX_SYSCTL 6'h06
`define IDX_TOGGLE 6'h07
`define IDX_ACT_HI 6'h08
`define IDX_ACT_LO 6'h09
`define IDX_PRESC 6'h0D
`define IDX_FLAG_CH 6'h0E
`define IDX_FLAG_OVF 6'h0F
`define IDX_CMP_BASE 6'h10
`define IDX_FINE_DIV 6'h2E
`define BIT_RUN 7
`define BIT_WAIT 6
`define BIT_FRZ 5
`define BIT_AUTOCLR 4
`define BIT_FINE 3
`define BIT_OVF_FLAG 7
`define ACT_HI_FIRST 4
`define CNT_MAX 16'hFFFF
`define CNT_ONE 16'h0001
`define TAP64_MASK 8'h3F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> logic/timer_pkg.sv
// types shared by the timer control block and its prescaler
// assumes timer_cfg.svh for the numeric constants
package timer_pkg;
   // compare pin action codes
   typedef enum logic [1:0] {
      ACT_NONE = 2'h0,
      ACT_TOGGLE = 2'h1,
      ACT_LOW = 2'h2,
      ACT_HIGH = 2'h3
   } compare_action_type;

   typedef struct packed {
      logic [7:0] stage;
      logic [7:0] fine;
   } presc_state_type;

   typedef struct packed {
      logic awRdy;
      logic wRdy;
      logic awHave;
      logic wHave;
      logic [5:0] awIdx;
      logic awOk;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [5:0] dir;
      logic [5:0] wrapTog;
      compare_action_type [5:0] act;
      logic [15:0] cnt;
      logic runEn;
      logic waitHalt;
      logic freezeHalt;
      logic autoClr;
      logic fineMode;
      logic fineLocked;
      logic [2:0] legSel;
      logic [7:0] fineVal;
      logic [5:0] chFlag;
      logic ovfFlag;
      logic [5:0][15:0] cmp;
      logic [5:0] pinOut;
      logic [5:0] pinDrive;
      logic paTick;
   } ctl_state_type;
endpackage : timer_pkg

// >>> logic/timer_prescaler.sv
// timer clock prescaler: legacy power-of-two divider or fine divider
// assumes run is already gated by timer enable and wait halting
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_prescaler (
   input wire logic clk, // bus clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic run, // prescaler may advance
   input wire logic fineMode, // 1: fine divider value sets the rate
   input wire logic [2:0] legacySel, // legacy divide by 2**sel
   input wire logic [7:0] fineVal, // fine divide by value + 1
   output logic tick, // one-cycle timer clock tick
   output logic tap64 // one-cycle divide-by-64 tap
);
   import timer_pkg::*;

   timer_pkg::presc_state_type s;
   timer_pkg::presc_state_type n;
   logic [7:0] legMask;
   logic fineHit;

   // tick decode; a stopped prescaler gives no tick and no tap
   always_comb begin
      legMask = (8'h01 << legacySel) - 8'h01;
      fineHit = (s.fine == fineVal);
      tick = run && (fineMode ? fineHit :
                     ((s.stage & legMask) == legMask));
      tap64 = run && ((s.stage & `TAP64_MASK) == `TAP64_MASK);
      n = s;
      if (run) begin
         n.stage = s.stage + 8'h01;
         n.fine = fineHit ? 8'h00 : s.fine + 8'h01;
      end
   end

   // stages are never realigned by a counter write
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule : timer_prescaler

// >>> logic/timer_force_count_control.sv
// timer control: counter, force strobe, system control, wrap toggle
// assumes an AXI4-Lite master and mode levels synchronous to clk
`timescale 1ns/1ps
`include "timer_cfg.svh"
// Function
// - force register always reads zero
// - force bit performs channel compare action
// - forced action acts like match, no flag
// - force and match together: force wins
// - unimplemented channel bits ignore writes, read zero
// - sixteen-bit counter counts up per tick
// - counter writable only in special mode
// - first period after write may differ
// - enable bit clear stops whole timer
// - divide-by-64 tap stops when inactive
// - halt-in-wait stops timer during wait
// - halt-in-wait also stops divide-by-64 tap
// - freeze halt stops counter, not tap
// - auto clear on capture read, compare write
// - auto clear: counter access clears overflow
// - scheme bit picks legacy or fine divider
// - scheme bit takes first write only
// - overflow toggles compare pin when enabled
// - overflow toggle beats forced compare action
// - direction bit: 0 capture, 1 compare
// - action codes none, toggle, low, high
module timer_force_count_control #(
   parameter int unsigned NCH = 6 // implemented channels
) (
   input wire logic clk, // bus clock, 40 MHz
   input wire logic reset_n, // synchronous reset, active low
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] awaddr, // write byte address
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write byte strobes
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   output logic [1:0] bresp, // write response code
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   input wire logic [31:0] araddr, // read byte address
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response code
   input wire logic specialMode, // counter writes allowed
   input wire logic waitMode, // processor in wait mode
   input wire logic freezeMode, // processor in debug freeze
   input wire logic [5:0] captureHit, // edge seen per channel
   output logic [5:0] chanOut, // compare pin level
   output logic [5:0] chanDrive, // pin driven by compare logic
   output logic [5:0] chanFlag, // channel event flags
   output logic overflowFlag, // timer overflow flag
   output logic paTick // divide-by-64 tap for pulse accumulator
);
   import timer_pkg::*;

   localparam logic [5:0] IMPL = 6'((1 << NCH) - 1);

   timer_pkg::ctl_state_type s;
   timer_pkg::ctl_state_type n;
   logic presRun;
   logic presTick;
   logic tap64;
   logic cntStep;
   logic wrapEvt;
   logic doWrite;
   logic doRead;
   logic forceReq;
   logic [5:0] matchHit;
   logic [5:0] togHit;
   logic [5:0] forceHit;
   logic [5:0] capHit;
   logic [5:0] flagSet;
   logic [5:0] pinNxt;
   logic [5:0] driveNxt;

   if (NCH < 1 || NCH > `MAX_CH) begin : g_bad_nch
      $error("timer: channel count out of range");
   end

   // one-hot select of the compare word register at index idx
   function automatic logic [5:0] chanSel(input logic [5:0] idx);
      logic [5:0] sel;
      sel = 6'h00;
      for (int i = 0; i < `MAX_CH; i++) begin
         sel[i] = IMPL[i] && (idx == `IDX_CMP_BASE + 6'(2 * i));
      end
      return sel;
   endfunction : chanSel

   // address decode shared by read and write paths
   function automatic logic regMapped(input logic [31:0] a);
      logic [5:0] idx;
      logic hit;
      idx = a[`IDX_MSB:`IDX_LSB];
      case (idx)
         `IDX_DIR, `IDX_FORCE, `IDX_CNT_HI, `IDX_CNT_LO, `IDX_SYSCTL,
         `IDX_TOGGLE, `IDX_ACT_HI, `IDX_ACT_LO, `IDX_PRESC,
         `IDX_FLAG_CH, `IDX_FLAG_OVF, `IDX_FINE_DIV: hit = 1'b1;
         default: hit = (chanSel(idx) != 6'h00);
      endcase
      return hit && (a[31:`IDX_MSB + 1] == '0) && (a[1:0] == 2'h0);
   endfunction : regMapped

   // byte-lane merge for the sixteen-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [31:0] d, input logic [3:0] st);
      logic [15:0] r;
      r = old;
      if (st[0]) r[7:0] = d[7:0];
      if (st[1]) r[15:8] = d[15:8];
      return r;
   endfunction : merge16

   // pin level after a compare action
   function automatic logic applyAct(input compare_action_type a,
         input logic cur);
      logic r;
      case (a)
         ACT_TOGGLE: r = !cur;
         ACT_LOW: r = 1'b0;
         ACT_HIGH: r = 1'b1;
         default: r = cur;
      endcase
      return r;
   endfunction : applyAct

   // register read value; stored unimplemented bits never get set
   function automatic logic [31:0] readWord(input logic [5:0] idx);
      logic [31:0] r;
      logic [5:0] sel;
      r = 32'h0000_0000;
      sel = chanSel(idx);
      case (idx)
         `IDX_DIR: r[5:0] = s.dir;
         `IDX_FORCE: r = 32'h0000_0000;
         `IDX_CNT_HI: r[15:0] = s.cnt;
         `IDX_CNT_LO: r[7:0] = s.cnt[7:0];
         `IDX_SYSCTL: begin
            r[`BIT_RUN] = s.runEn;
            r[`BIT_WAIT] = s.waitHalt;
            r[`BIT_FRZ] = s.freezeHalt;
            r[`BIT_AUTOCLR] = s.autoClr;
            r[`BIT_FINE] = s.fineMode;
         end
         `IDX_TOGGLE: r[5:0] = s.wrapTog;
         `IDX_ACT_HI: r[3:0] = {s.act[5], s.act[4]};
         `IDX_ACT_LO: r[7:0] = {s.act[3], s.act[2], s.act[1], s.act[0]};
         `IDX_PRESC: r[2:0] = s.legSel;
         `IDX_FLAG_CH: r[5:0] = s.chFlag;
         `IDX_FLAG_OVF: r[`BIT_OVF_FLAG] = s.ovfFlag;
         `IDX_FINE_DIV: r[7:0] = s.fineVal;
         default: begin
            for (int i = 0; i < `MAX_CH; i++) begin
               if (sel[i]) r[15:0] = s.cmp[i];
            end
         end
      endcase
      return r;
   endfunction : readWord

   // run gating: freeze halts only the counter, so the tap keeps going
   assign presRun = s.runEn && !(waitMode && s.waitHalt);
   assign cntStep = presTick && !(freezeMode && s.freezeHalt);
   assign wrapEvt = cntStep && (s.cnt == `CNT_MAX);
   assign doWrite = s.awHave && s.wHave && !s.bValid;
   assign doRead = arvalid && s.arRdy;
   assign forceReq = doWrite && s.awOk && (s.awIdx == `IDX_FORCE)
      && s.wStrb[0];

   timer_prescaler u_presc (
      .clk(clk),
      .reset_n(reset_n),
      .run(presRun),
      .fineMode(s.fineMode),
      .legacySel(s.legSel),
      .fineVal(s.fineVal),
      .tick(presTick),
      .tap64(tap64)
   );

   // per-channel pin and flag decisions
   for (genvar i = 0; i < `MAX_CH; i++) begin : g_ch
      assign matchHit[i] = IMPL[i] && s.dir[i] && cntStep
         && (s.cnt + `CNT_ONE == s.cmp[i]);
      assign togHit[i] = IMPL[i] && s.dir[i] && s.wrapTog[i]
         && wrapEvt;
      assign forceHit[i] = IMPL[i] && s.dir[i] && forceReq
         && s.wData[i];
      assign capHit[i] = IMPL[i] && !s.dir[i] && captureHit[i];
      // a same-cycle force suppresses the flag of a real match
      assign flagSet[i] = (matchHit[i] && !forceHit[i])
         || capHit[i];
      // overflow toggle first, then force or match
      assign pinNxt[i] = togHit[i] ? !s.pinOut[i] :
         (forceHit[i] || matchHit[i]) ?
         applyAct(s.act[i], s.pinOut[i]) : s.pinOut[i];
      assign driveNxt[i] = IMPL[i] && s.dir[i] && (s.act[i] != ACT_NONE);
   end

   // next state: timer, bus slave, register side effects
   always_comb begin
      logic [5:0] chClr;
      logic ovfClr;
      logic [5:0] rIdx;
      logic [5:0] wSel;
      logic [5:0] rSel;
      logic [31:0] wd;
      chClr = 6'h00;
      ovfClr = 1'b0;
      rIdx = araddr[`IDX_MSB:`IDX_LSB];
      wSel = chanSel(s.awIdx);
      rSel = chanSel(rIdx);
      wd = s.wData;
      n = s;
      // counter advance; a bus write in the same cycle overrides it, a low-byte write only bits 7:0
      if (cntStep) n.cnt = s.cnt + `CNT_ONE;
      // address and data are taken independently
      if (awvalid && s.awRdy) begin
         n.awHave = 1'b1;
         n.awIdx = awaddr[`IDX_MSB:`IDX_LSB];
         n.awOk = regMapped(awaddr);
      end
      if (wvalid && s.wRdy) begin
         n.wHave = 1'b1;
         n.wData = wdata;
         n.wStrb = wstrb;
      end
      if (s.bValid && bready) n.bValid = 1'b0;
      if (doWrite) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bValid = 1'b1;
         n.bResp = s.awOk ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (doWrite && s.awOk) begin
         case (s.awIdx)
            `IDX_DIR: if (s.wStrb[0]) n.dir = wd[5:0] & IMPL;
            `IDX_SYSCTL: if (s.wStrb[0]) begin
               n.runEn = wd[`BIT_RUN];
               n.waitHalt = wd[`BIT_WAIT];
               n.freezeHalt = wd[`BIT_FRZ];
               n.autoClr = wd[`BIT_AUTOCLR];
               if (!s.fineLocked) begin
                  n.fineMode = wd[`BIT_FINE];
                  n.fineLocked = 1'b1;
               end
            end
            `IDX_TOGGLE: if (s.wStrb[0]) n.wrapTog = wd[5:0] & IMPL;
            `IDX_ACT_HI: if (s.wStrb[0]) begin
               for (int i = `ACT_HI_FIRST; i < `MAX_CH; i++) begin
                  if (IMPL[i]) n.act[i] = compare_action_type'(
                     wd[2 * (i - `ACT_HI_FIRST) +: 2]);
               end
            end
            `IDX_ACT_LO: if (s.wStrb[0]) begin
               for (int i = 0; i < `ACT_HI_FIRST; i++) begin
                  if (IMPL[i]) n.act[i] = compare_action_type'(
                     wd[2 * i +: 2]);
               end
            end
            `IDX_PRESC: if (s.wStrb[0]) n.legSel = wd[2:0];
            `IDX_FINE_DIV: if (s.wStrb[0]) n.fineVal = wd[7:0];
            // write-one-to-clear is the normal flag clearing path
            `IDX_FLAG_CH: if (s.wStrb[0]) chClr = wd[5:0] & IMPL;
            `IDX_FLAG_OVF: if (s.wStrb[0]) ovfClr = wd[`BIT_OVF_FLAG];
            `IDX_CNT_HI: begin
               if (specialMode) n.cnt = merge16(s.cnt, wd, s.wStrb);
               if (s.autoClr) ovfClr = 1'b1;
            end
            `IDX_CNT_LO: begin
               // prescaler keeps its phase, so the next period is uneven
               if (specialMode && s.wStrb[0]) n.cnt[7:0] = wd[7:0];
               if (s.autoClr) ovfClr = 1'b1;
            end
            default: begin
               for (int i = 0; i < `MAX_CH; i++) begin
                  if (wSel[i]) begin
                     n.cmp[i] = merge16(s.cmp[i], wd, s.wStrb);
                     if (s.autoClr && s.dir[i]) chClr[i] = 1'b1;
                  end
               end
            end
         endcase
      end
      n.awRdy = !n.awHave && !n.bValid;
      n.wRdy = !n.wHave && !n.bValid;
      // read path: one read in flight, answer one cycle after acceptance
      if (s.rValid && rready) n.rValid = 1'b0;
      if (doRead) begin
         n.rValid = 1'b1;
         if (regMapped(araddr)) begin
            n.rData = readWord(rIdx);
            n.rResp = `RESP_OKAY;
            if (s.autoClr && (rIdx == `IDX_CNT_HI
                  || rIdx == `IDX_CNT_LO)) ovfClr = 1'b1;
            if (s.autoClr) chClr = chClr | (rSel & ~s.dir);
         end else begin
            n.rData = 32'h0000_0000;
            n.rResp = `RESP_SLVERR;
         end
      end
      n.arRdy = !n.rValid;
      // capture latches the count; it beats a same-cycle bus write
      for (int i = 0; i < `MAX_CH; i++) begin
         if (capHit[i]) n.cmp[i] = s.cnt;
      end
      // flags: a set in the clearing cycle wins
      n.chFlag = (s.chFlag & ~chClr) | flagSet;
      n.ovfFlag = (s.ovfFlag && !ovfClr) || wrapEvt;
      n.pinOut = pinNxt & IMPL;
      n.pinDrive = driveNxt;
      n.paTick = tap64;
   end

   // all state in one register; reset clears everything
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign awready = s.awRdy;
   assign wready = s.wRdy;
   assign bvalid = s.bValid;
   assign bresp = s.bResp;
   assign arready = s.arRdy;
   assign rvalid = s.rValid;
   assign rdata = s.rData;
   assign rresp = s.rResp;
   assign chanOut = s.pinOut;
   assign chanDrive = s.pinDrive;
   assign chanFlag = s.chFlag;
   assign overflowFlag = s.ovfFlag;
   assign paTick = s.paTick;
endmodule : timer_force_count_control

// >>> tb/timer_force_count_monitor.sv
// concurrent checks on the timer control block ports
// assumes one bus transfer at a time and full write strobes
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_force_count_monitor #(
   parameter int unsigned NCH = 6 // implemented channels
) (
   input wire logic clk, // bus clock
   input wire logic reset_n, // sync reset, active low
   input wire logic awvalid, // aw valid
   input wire logic awready, // aw ready
   input wire logic [31:0] awaddr, // aw address
   input wire logic wvalid, // w valid
   input wire logic wready, // w ready
   input wire logic [31:0] wdata, // w data
   input wire logic [3:0] wstrb, // w strobes
   input wire logic bvalid, // b valid
   input wire logic bready, // b ready
   input wire logic [1:0] bresp, // b code
   input wire logic arvalid, // ar valid
   input wire logic arready, // ar ready
   input wire logic [31:0] araddr, // ar address
   input wire logic rvalid, // r valid
   input wire logic rready, // r ready
   input wire logic [31:0] rdata, // r data
   input wire logic [1:0] rresp, // r code
   input wire logic specialMode, // counter writable
   input wire logic waitMode, // wait mode
   input wire logic freezeMode, // freeze mode
   input wire logic [5:0] captureHit, // capture edges
   input wire logic [5:0] chanOut, // pin levels
   input wire logic [5:0] chanDrive, // pin enables
   input wire logic [5:0] chanFlag, // channel flags
   input wire logic overflowFlag, // overflow flag
   input wire logic paTick // divide-by-64 tap
);
   logic [5:0] wIdx_reg;
   logic [31:0] wDat_reg;
   logic [7:0] ctl_reg;
   logic dir_reg;
   logic [1:0] act_reg;
   logic [7:0] gap_reg;
   logic runOk;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // shadows commit at the response handshake, a cycle after the design
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctl_reg <= 8'h00;
         dir_reg <= 1'b0;
         act_reg <= 2'h0;
      end else begin
         if (awvalid && awready) wIdx_reg <= awaddr[`IDX_MSB:`IDX_LSB];
         if (wvalid && wready) wDat_reg <= wdata;
         if (bvalid && bready && wIdx_reg == `IDX_SYSCTL) ctl_reg <= wDat_reg[7:0];
         if (bvalid && bready && wIdx_reg == `IDX_DIR) dir_reg <= wDat_reg[0];
         if (bvalid && bready && wIdx_reg == `IDX_ACT_LO) act_reg <= wDat_reg[1:0];
      end
   end
   // quiet cycles of the tap while it must run; bvalid masks the lag
   assign runOk = ctl_reg[7] && !(ctl_reg[6] && waitMode) && !bvalid;
   always_ff @(posedge clk) begin
      if (!reset_n || paTick || !runOk) gap_reg <= 8'h00;
      else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
   end
   a_force_rd_zero: assert property (arvalid && arready &&
      araddr[7:2] == `IDX_FORCE |=> rdata == 32'h0000_0000)
      else $error("force register read not zero");
   a_absent_bits_zero: assert property (arvalid && arready &&
      araddr[7:2] inside {`IDX_DIR, `IDX_TOGGLE} |=> rdata[31:6] == '0)
      else $error("absent channel bits read nonzero");
   a_force_pin_act: assert property ($rose(bvalid) &&
      wIdx_reg == `IDX_FORCE && wDat_reg[0] && dir_reg && act_reg == 2'h3
      |-> chanOut[0] && chanDrive[0]) else $error("forced action missing");
   a_force_no_flag: assert property ($rose(bvalid) &&
      wIdx_reg == `IDX_FORCE && wDat_reg[0] && dir_reg && !$past(chanFlag[0])
      |-> !chanFlag[0]) else $error("forced compare set the flag");
   a_flag_kept_idle: assert property (overflowFlag && awready &&
      wready && arready && !arvalid && !awvalid && !wvalid |=> overflowFlag)
      else $error("overflow flag cleared without access");
   a_tap_off_stop: assert property ((!ctl_reg[7] && !bvalid) [*4]
      |-> !paTick) else $error("tap pulse while timer off");
   a_tap_wait_stop: assert property ((ctl_reg[6] && waitMode &&
      !bvalid) [*4] |-> !paTick) else $error("tap pulse in wait halt");
   a_tap_keeps_run: assert property (gap_reg <= 8'h46)
      else $error("tap missing while timer runs");
   a_tap_pulse_gap: assert property (paTick |=> !paTick [*8])
      else $error("tap pulses too close");
endmodule : timer_force_count_monitor
bind timer_force_count_control timer_force_count_monitor #(.NCH(NCH))
   u_timer_force_count_monitor (.clk, .reset_n, .awvalid, .awready, .awaddr,
   .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
   .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .specialMode,
   .waitMode, .freezeMode, .captureHit, .chanOut, .chanDrive, .chanFlag,
   .overflowFlag, .paTick);

// >>> tb/timer_pin_model.sv
// far side of the channels: capture edge source and pin level
// assumes the bench asks for edges one cycle at a time
`timescale 1ns/1ps
module timer_pin_model (
   input wire logic clk, // bus clock
   input wire logic reset_n, // sync reset, active low
   input wire logic [5:0] hitReq, // edge request
   input wire logic [5:0] chanOut, // compare level
   input wire logic [5:0] chanDrive, // compare enable
   output logic [5:0] captureHit, // one-cycle edge pulse
   output logic [5:0] pinLevel // level on the pin
);
   logic [5:0] lastLevel_reg;
   // edge detector outside the block reports one cycle late
   always @(posedge clk) begin
      captureHit <= hitReq;
      lastLevel_reg <= reset_n ? pinLevel : 6'h00;
   end
   // no pull: a released pin flips each cycle so no stale level passes
   assign pinLevel = (chanDrive & chanOut) | (~chanDrive & ~lastLevel_reg);
endmodule : timer_pin_model

// >>> tb/timer_force_count_control_tb.sv
// self-checking bench for the timer control block
// assumes the bound checker and the pin model beside the design
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_force_count_control_tb;
   import timer_pkg::*;
   localparam logic [7:0] SYS_TAB [3] = '{8'h00, 8'hc0, 8'ha0};
   localparam logic [2:0] WAIT_TAB = 3'b010;
   localparam logic [2:0] FRZ_TAB = 3'b100;
   logic clk = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b1, arvalid = 1'b0, rready = 1'b1, specialMode = 1'b0;
   logic waitMode = 1'b0, freezeMode = 1'b0;
   logic [31:0] awaddr = 32'h0000_0000, araddr = 32'h0000_0000;
   logic [31:0] wdata = 32'h0000_0000, seed = 32'h0000_c9cc;
   logic [3:0] wstrb = 4'hf;
   logic [5:0] hitReq = 6'h00;
   logic awready, wready, bvalid, arready, rvalid, overflowFlag, paTick;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [5:0] captureHit, chanOut, chanDrive, chanFlag, pinLevel;
   logic [33:0] expQ [$];
   int n_fail = 0;
   int num_checks = 0;
   initial begin
      forever #12.5 clk = ~clk;
   end
   timer_force_count_control #(.NCH(6)) u_timer_force_count_control (.clk,
      .reset_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
      .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
      .rdata, .rresp, .specialMode, .waitMode, .freezeMode, .captureHit,
      .chanOut, .chanDrive, .chanFlag, .overflowFlag, .paTick);
   timer_pin_model u_timer_pin_model (.clk, .reset_n, .hitReq, .chanOut,
      .chanDrive, .captureHit, .pinLevel);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input string what, input logic [33:0] seen,
                        input logic [33:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_sim;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic stuck(input string what);
      n_fail++;
      $display("CHECK FAILED %s expected done seen timeout", what);
      end_sim();
   endtask : stuck
   // one transfer; each channel is held until its own handshake edge
   task automatic bus(input logic isWr, input logic [5:0] idx,
                      input logic [31:0] d, input logic [33:0] exp);
      logic a, w, r;
      int n;
      r = 1'b0;
      expQ.push_back(exp);
      if (isWr) begin
         awaddr <= {24'h00_0000, idx, 2'b00};
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
      end else begin
         araddr <= {24'h00_0000, idx, 2'b00};
         arvalid <= 1'b1;
      end
      for (n = 0; n < 40 && !r; n++) begin
         @(negedge clk);
         a = (awvalid && awready) || (arvalid && arready);
         w = wvalid && wready;
         r = bvalid || rvalid;
         @(posedge clk);
         if (a) awvalid <= 1'b0;
         if (a) arvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      if (!r) stuck("bus");
   endtask : bus
   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d, 34'h0_0000_0000);
   endtask : wr
   task automatic rd(input logic [5:0] idx, input logic [33:0] exp);
      bus(1'b0, idx, 32'h0000_0000, exp);
   endtask : rd
   // answers meet the oldest note at their handshake edge
   always @(posedge clk) begin
      if (rvalid === 1'b1 && rready && expQ.size() > 0) begin
         check("read", {rresp, rdata}, expQ.pop_front());
      end
      if (bvalid === 1'b1 && bready && expQ.size() > 0) begin
         check("write", {bresp, 32'h0000_0000}, expQ.pop_front());
      end
   end
   initial begin
      int n;
      int cnt;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // reset values, a refused address and a masked random write
      rd(`IDX_TOGGLE, 34'h0_0000_0000);
      rd(6'h03, {`RESP_SLVERR, 32'h0000_0000});
      seed = lfsr(seed);
      wr(`IDX_TOGGLE, seed);
      rd(`IDX_TOGGLE, {`RESP_OKAY, 26'h0, seed[5:0]});
      $display("test registers done");
      // forced compare with action high; fine scheme locked by first write
      wr(`IDX_SYSCTL, 32'h0000_0008);
      wr(`IDX_DIR, 32'h0000_0001);
      wr(`IDX_ACT_LO, 32'h0000_0003);
      wr(`IDX_FORCE, 32'h0000_0001);
      @(negedge clk);
      check("force pin", {chanDrive[0], chanOut[0], pinLevel[0]}, 3'b111);
      check("force flag", chanFlag[0], 1'b0);
      @(posedge clk);
      rd(`IDX_FORCE, 34'h0_0000_0000);
      // counter writable only in special mode, then run through the wrap
      wr(`IDX_CNT_HI, 32'h0000_1234);
      rd(`IDX_CNT_HI, 34'h0_0000_0000);
      specialMode <= 1'b1;
      wr(`IDX_CMP_BASE, 32'h0000_fff8);
      wr(`IDX_TOGGLE, 32'h0000_0001);
      wr(`IDX_CNT_HI, 32'h0000_fff0);
      rd(`IDX_CNT_HI, {`RESP_OKAY, 32'h0000_fff0});
      specialMode <= 1'b0;
      wr(`IDX_SYSCTL, 32'h0000_0080);
      for (n = 0; n < 100 && overflowFlag !== 1'b1; n++) @(posedge clk);
      if (n == 100) stuck("wrap");
      @(negedge clk);
      check("wrap", {overflowFlag, chanOut[0]}, 2'b10);
      check("match", chanFlag[0], 1'b1);
      @(posedge clk);
      rd(`IDX_SYSCTL, {`RESP_OKAY, 32'h0000_0088});
      wr(`IDX_CNT_LO, 32'h0000_0000);
      @(negedge clk);
      check("flag kept", overflowFlag, 1'b1);
      @(posedge clk);
      wr(`IDX_SYSCTL, 32'h0000_0090);
      wr(`IDX_CNT_LO, 32'h0000_0000);
      @(negedge clk);
      check("flag cleared", overflowFlag, 1'b0);
      @(posedge clk);
      $display("test counter done");
      // off, wait halt, freeze halt: counter held, tap only in freeze
      for (int i = 0; i < 3; i++) begin
         waitMode <= WAIT_TAB[i];
         freezeMode <= FRZ_TAB[i];
         wr(`IDX_SYSCTL, {24'h00_0000, SYS_TAB[i]});
         specialMode <= 1'b1;
         wr(`IDX_CNT_HI, 32'h0000_0300 + i);
         specialMode <= 1'b0;
         cnt = 0;
         repeat (140) begin
            @(posedge clk);
            cnt += paTick;
         end
         check("tap", cnt > 0, FRZ_TAB[i]);
         rd(`IDX_CNT_HI, {`RESP_OKAY, 32'h0000_0300 + i});
      end
      $display("test stop modes done");
      // capture on channel 1, then auto clear by reading its value
      freezeMode <= 1'b0;
      wr(`IDX_SYSCTL, 32'h0000_0010);
      specialMode <= 1'b1;
      wr(`IDX_CNT_HI, 32'h0000_0420);
      specialMode <= 1'b0;
      hitReq <= 6'h02;
      @(posedge clk);
      hitReq <= 6'h00;
      repeat (3) @(negedge clk);
      check("capture flag", chanFlag[1], 1'b1);
      @(posedge clk);
      rd(`IDX_CMP_BASE + 6'h02, {`RESP_OKAY, 32'h0000_0420});
      @(negedge clk);
      check("auto clear", chanFlag[1], 1'b0);
      $display("test capture done");
      end_sim();
   end
endmodule : timer_force_count_control_tb
